// file: design/iahi_core.sv
// isa adapter host interface: decode, irq routing, dma requests, adc fifo
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - decode ten host address lines only
// - bits nine-five select board, four-zero register
// - base select resets to 220 hex
// - read/write strobes, 8 and 16 bit cycles
// - drive select, ready, width back to host
// - enabled requests drive shared three-state line
// - one of eight irq lines selectable
// - six sources, each enabled and cleared
// - adc fifo service and acquisition done
// - dma terminal count on channel a or b
// - dac fifo, dac done, dac update fall
// - dma request for adc data, dac space
// - sixteen bit dma channel choice
// - channel assignment and single/dual mode
// - unipolar straight binary, bipolar twos complement
// - results pushed into 512 word fifo
// - overflow flagged when full fifo pushed
// - nonempty fifo raises dma or irq
// - one channel config register with gain and polarity fields
// - differential or single ended mux routing
module iahi_core (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // host i/o channel
   input wire logic [9:0] sa,
   input wire logic iow_n,
   input wire logic ior_n,
   input wire logic aen,
   input wire logic sbhe_n,
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic sd_oe_n,
   output logic board_sel,
   output logic iochrdy,
   output logic iocs16_n,
   // board configuration and interrupt routing
   input wire logic [4:0] base_sel,
   input wire logic base_load,
   input wire logic [2:0] irq_line_sel,
   input wire logic [5:0] irq_enable,
   output logic [7:0] irq_out,
   output logic [7:0] irq_oe_n,
   // dma channel control
   input wire logic [1:0] dma_chan_sel,
   input wire logic dma_dual,
   input wire logic adc_dma_en,
   input wire logic dack_n,
   input wire logic tc_a,
   input wire logic tc_b,
   output logic drq_a,
   output logic drq_b,
   output logic [1:0] dma_chan,
   // converter and dac side events
   input wire logic adc_done,
   input wire logic [15:0] adc_raw,
   input wire logic acq_done,
   input wire logic dac_fifo_room,
   input wire logic dac_done,
   input wire logic dac_update,
   // fifo status and analog input control
   output logic fifo_overflow,
   output logic [8:0] active_cfg,
   output logic [3:0] mux_pos,
   output logic [3:0] mux_neg,
   output logic mux_neg_gnd
);
   // synchronised host pins
   logic [2:0] s_iow, s_ior, s_aen, s_dack, s_tca, s_tcb, s_upd;
   logic [9:0] s_sa1, s_sa2;
   logic [15:0] s_sd1, s_sd2;

   // base select and pending flags
   logic [4:0] base;
   logic [5:0] pend;

   // adc result fifo storage and pointers
   logic [15:0] mem [0:iahi_pkg::fifo_depth-1];
   logic [8:0] wr_ptr, rd_ptr;
   logic [9:0] count;

   // channel configuration
   logic [8:0] chcfg;
   logic [3:0] chan_num;

   // two-flop synchronisers; third stage only for edge detect
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_iow <= 3'h7;
         s_ior <= 3'h7;
         s_aen <= 3'h7;
         s_dack <= 3'h7;
         s_tca <= 3'h0;
         s_tcb <= 3'h0;
         s_upd <= 3'h7;
      end else begin
         s_iow <= {s_iow[1:0], iow_n};
         s_ior <= {s_ior[1:0], ior_n};
         s_aen <= {s_aen[1:0], aen};
         s_dack <= {s_dack[1:0], dack_n};
         s_tca <= {s_tca[1:0], tc_a};
         s_tcb <= {s_tcb[1:0], tc_b};
         s_upd <= {s_upd[1:0], dac_update};
      end
   end

   // address and data pass the same two stages as the strobes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_sa1 <= 10'h000;
         s_sa2 <= 10'h000;
         s_sd1 <= 16'h0000;
         s_sd2 <= 16'h0000;
      end else begin
         s_sa1 <= sa;
         s_sa2 <= s_sa1;
         s_sd1 <= sd_in;
         s_sd2 <= s_sd1;
      end
   end

   // address decode
   wire [4:0] reg_addr = s_sa2[iahi_pkg::reg_w-1:0];
   wire addr_hit = s_sa2[iahi_pkg::addr_w-1:iahi_pkg::sel_lo] == base;

   // cycle qualification
   wire io_cycle = !s_aen[1] && s_dack[1];
   wire rd_act = !s_ior[1];
   wire wr_act = !s_iow[1];
   wire sel = addr_hit && io_cycle && (rd_act || wr_act);

   // strobe leading edges
   wire rd_start = sel && !s_ior[1] && s_ior[2];
   wire wr_start = sel && !s_iow[1] && s_iow[2];

   // word registers sit at even offsets
   wire word_reg = reg_addr[0] == 1'b0;

   // fifo level flags
   wire fifo_empty = count == 10'h000;
   wire fifo_full = count == 10'(iahi_pkg::fifo_depth);

   // fifo pops by host read or dma acknowledge
   wire fifo_rd_host = rd_start && reg_addr == iahi_pkg::off_adc_fifo;
   wire dma_rd = !s_dack[1] && s_dack[2] && adc_dma_en;
   wire pop = (fifo_rd_host || dma_rd) && !fifo_empty;
   wire push = adc_done && !fifo_full;

   // result format
   wire bip = chcfg[iahi_pkg::chcfg_bip_bit];
   // bipolar results arrive offset binary and leave twos complement
   wire [15:0] adc_fmt = bip ? (adc_raw ^ iahi_pkg::bip_flip) : adc_raw;

   // register writes
   wire clr_wr = wr_start && reg_addr == iahi_pkg::off_irq_clear;
   wire cfg_wr = wr_start && reg_addr == iahi_pkg::off_chan_cfg;
   wire gain_ok = s_sd2[6:4] <= iahi_pkg::gain_max[2:0];

   // interrupt events
   wire tc_fall = (s_tca[1] && !s_tca[2]) || (s_tcb[1] && !s_tcb[2]);
   wire upd_fall = !s_upd[1] && s_upd[2];
   wire [5:0] events = {upd_fall, dac_done, dac_fifo_room, tc_fall,
      acq_done, !fifo_empty && !adc_dma_en};

   // pending flag update
   wire [5:0] clr_mask = clr_wr ? s_sd2[5:0] : 6'h00;
   wire [5:0] next_pend = (pend & ~clr_mask) | events;
   wire irq_any = |(pend & irq_enable);

   // read data selection; a full fifo reports a count of all ones
   wire [8:0] count_rpt = fifo_full ? 9'h1ff : count[8:0];
   wire [15:0] status_word = {count_rpt, fifo_overflow, pend};
   wire [15:0] read_word = reg_addr == iahi_pkg::off_adc_fifo ?
      mem[rd_ptr] : (reg_addr == iahi_pkg::off_status ? status_word :
      {7'h00, chcfg});

   // dma request next values
   wire next_drq_a = adc_dma_en && !fifo_empty && !pop;
   wire next_drq_b = dma_dual && dac_fifo_room;

   // mux routing
   assign chan_num = chcfg[3:0];
   wire se_mode = chcfg[iahi_pkg::chcfg_se_bit];
   wire [3:0] next_mux_pos = se_mode ? chan_num : {1'b0, chan_num[2:0]};
   wire [3:0] next_mux_neg = se_mode ? 4'h0 : {1'b1, chan_num[2:0]};

   // base select register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) base <= iahi_pkg::base_reset;
      else if (base_load) base <= base_sel;
   end

   // host handshake outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         board_sel <= 1'b0;
         iochrdy <= 1'b1;
         iocs16_n <= 1'b1;
         sd_oe_n <= 1'b1;
      end else begin
         board_sel <= sel;
         iochrdy <= !(rd_start || wr_start);
         iocs16_n <= !(sel && word_reg);
         sd_oe_n <= !(sel && rd_act);
      end
   end

   // read data register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) sd_out <= 16'h0000;
      else if (rd_start) sd_out <= read_word;
      else if (dma_rd) sd_out <= mem[rd_ptr];
   end

   // one sticky flag per source; set wins over clear
   genvar gp;
   generate
      for (gp = 0; gp < iahi_pkg::n_src; gp++) begin : g_pend
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) pend[gp] <= 1'b0;
            else pend[gp] <= next_pend[gp];
         end
      end
   endgenerate

   // only the chosen line is driven; others released
   genvar gi;
   generate
      for (gi = 0; gi < iahi_pkg::n_irq; gi++) begin : g_irq
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               irq_out[gi] <= 1'b0;
               irq_oe_n[gi] <= 1'b1;
            end else begin
               irq_out[gi] <= irq_any;
               irq_oe_n[gi] <= !(irq_any && irq_line_sel == 3'(gi));
            end
         end
      end
   endgenerate

   // dma channel and requests
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drq_a <= 1'b0;
         drq_b <= 1'b0;
         dma_chan <= 2'h0;
      end else begin
         dma_chan <= dma_chan_sel;
         drq_a <= next_drq_a;
         drq_b <= next_drq_b;
      end
   end

   // fifo storage write
   always_ff @(posedge ref_clk) begin
      if (push) mem[wr_ptr] <= adc_fmt;
   end

   // fifo pointers, level and overflow
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         count <= 10'h000;
         fifo_overflow <= 1'b0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 9'h001;
         if (pop) rd_ptr <= rd_ptr + 9'h001;
         count <= count + 10'(push) - 10'(pop);
         if (adc_done && fifo_full) fifo_overflow <= 1'b1;
         else if (clr_wr && s_sd2[6]) fifo_overflow <= 1'b0;
      end
   end

   // channel configuration register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) chcfg <= iahi_pkg::chcfg_reset;
      else if (cfg_wr && gain_ok)
         chcfg <= s_sd2[8:0];
   end

   // configuration and mux outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         active_cfg <= 9'h000;
         mux_pos <= 4'h0;
         mux_neg <= 4'h8;
         mux_neg_gnd <= 1'b0;
      end else begin
         active_cfg <= chcfg;
         mux_pos <= next_mux_pos;
         mux_neg <= next_mux_neg;
         mux_neg_gnd <= se_mode;
      end
   end

endmodule : iahi_core
`default_nettype wire

// file: design/iahi_pkg.sv
// constants for the adapter host interface
package iahi_pkg;
   localparam logic [4:0] base_reset = 5'h11;
   localparam int addr_w = 10;
   localparam int sel_lo = 5;
   localparam int reg_w = 5;
   localparam int fifo_depth = 512;
   localparam int ptr_w = 9;
   localparam int cnt_w = 10;
   localparam int n_src = 6;
   localparam int n_irq = 8;
   localparam int src_adc_fifo = 0;
   localparam int src_acq_done = 1;
   localparam int src_dma_tc = 2;
   localparam int src_dac_fifo = 3;
   localparam int src_dac_done = 4;
   localparam int src_dac_upd = 5;
   localparam logic [3:0] gain_max = 4'h6;
   localparam logic [4:0] off_adc_fifo = 5'h00;
   localparam logic [4:0] off_irq_clear = 5'h02;
   localparam logic [4:0] off_status = 5'h04;
   localparam logic [4:0] off_chan_cfg = 5'h06;
   localparam logic [15:0] bip_flip = 16'h8000;
   localparam int chcfg_w = 9;
   localparam logic [8:0] chcfg_reset = 9'h000;
   localparam int chcfg_se_bit = 8;
   localparam int chcfg_bip_bit = 7;
   localparam int chcfg_gain_lo = 4;
endpackage : iahi_pkg

// file: sim/iahi_core_monitor.sv
// concurrent checks on the host interface ports
`timescale 1ns/10ps
`default_nettype none
module iahi_core_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic aen,
   input wire logic iow_n,
   input wire logic board_sel,
   input wire logic iochrdy,
   input wire logic iocs16_n,
   input wire logic sd_oe_n,
   input wire logic [5:0] irq_enable,
   input wire logic [7:0] irq_out,
   input wire logic [7:0] irq_oe_n,
   input wire logic dma_dual,
   input wire logic drq_a,
   input wire logic drq_b,
   input wire logic fifo_overflow
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   dma_no_sel_a: assert property (aen [*4] |-> !board_sel)
      else $error("board selected during dma cycle");
   irq_one_a: assert property ($onehot0(~irq_oe_n))
      else $error("more than one request line driven");
   irq_off_a: assert property ((irq_enable == 6'h00) [*4] |-> &irq_oe_n)
      else $error("request driven with no source enabled");
   irq_level_a: assert property (!(&irq_oe_n) |-> |(irq_out & ~irq_oe_n))
      else $error("driven request line not active");
   ovf_hold_a: assert property ((fifo_overflow && iow_n) [*5] |=> fifo_overflow)
      else $error("overflow flag lost without clear");
   rdy_short_a: assert property ($fell(iochrdy) |=> iochrdy)
      else $error("ready held low too long");
   cs16_sel_a: assert property (!iocs16_n |-> board_sel || $past(board_sel))
      else $error("word size flag without select");
   drive_sel_a: assert property (!sd_oe_n |-> board_sel || $past(board_sel))
      else $error("data driven without select");
   single_b_a: assert property (!dma_dual [*3] |-> !drq_b)
      else $error("second request in single mode");
   cover property (!sd_oe_n);
   cover property ($rose(fifo_overflow));
   cover property ($rose(drq_a));
   cover property (!(&irq_oe_n));
endmodule : iahi_core_monitor
bind iahi_core iahi_core_monitor iahi_core_monitor_i (.ref_clk, .rst, .aen,
   .iow_n, .board_sel, .iochrdy, .iocs16_n, .sd_oe_n, .irq_enable, .irq_out,
   .irq_oe_n, .dma_dual, .drq_a, .drq_b, .fifo_overflow);
`default_nettype wire

// file: sim/iahi_core_tb.sv
// self-checking bench for the host interface block
`timescale 1ns/10ps
`default_nettype none
module iahi_core_tb;
   logic ref_clk, rst, iow_n, ior_n, aen, base_load, dma_dual, adc_dma_en;
   logic dack_n, adc_done, sd_oe_n, board_sel, iochrdy, iocs16_n, drq_a;
   logic drq_b, fifo_overflow, sel, cs;
   logic mux_neg_gnd, oe;
   logic [8:0] active_cfg;
   logic [3:0] mux_pos, mux_neg;
   logic [9:0] sa;
   logic [15:0] sd_in, adc_raw, sd_out, rd;
   logic [4:0] base_sel;
   logic [2:0] irq_line_sel;
   logic [5:0] irq_enable, ev;
   logic [1:0] dma_chan_sel, dma_chan;
   logic [7:0] irq_out, irq_oe_n, irq_wire;
   logic [15:0] q[$];
   int error_cnt = 0;
   int checks_done = 0;
   iahi_core iahi_core_i (.ref_clk, .rst, .sa, .iow_n, .ior_n, .aen,
      .sbhe_n(1'b1), .sd_in, .sd_out, .sd_oe_n, .board_sel, .iochrdy,
      .iocs16_n, .base_sel, .base_load, .irq_line_sel, .irq_enable,
      .irq_out, .irq_oe_n, .dma_chan_sel, .dma_dual, .adc_dma_en, .dack_n,
      .tc_a(ev[2]), .tc_b(ev[0]), .drq_a, .drq_b, .dma_chan, .adc_done,
      .adc_raw, .acq_done(ev[1]), .dac_fifo_room(ev[3]), .dac_done(ev[4]),
      .dac_update(!ev[5]), .fifo_overflow, .active_cfg, .mux_pos, .mux_neg,
      .mux_neg_gnd);
   iahi_host_model iahi_host_model_i (.irq_out, .irq_oe_n, .irq_wire);
   task automatic give_verdict();
      if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask : chkb
   // word-wide host cycle only
   task automatic io(input logic wr, input logic [9:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      sa <= a;
      sd_in <= d;
      iow_n <= !wr;
      ior_n <= wr;
      repeat (6) @(posedge ref_clk);
      rd = sd_out;
      sel = board_sel;
      cs = iocs16_n;
      oe = sd_oe_n;
      iow_n <= 1'b1;
      ior_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask : io
   task automatic push(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         adc_raw <= 16'($urandom);
         adc_done <= 1'b1;
         @(posedge ref_clk);
         adc_done <= 1'b0;
         q.push_back(adc_raw);
      end
      repeat (4) @(posedge ref_clk);
   endtask : push
   task automatic ld(input logic [4:0] b);
      @(posedge ref_clk);
      base_sel <= b;
      base_load <= 1'b1;
      @(posedge ref_clk);
      base_load <= 1'b0;
   endtask : ld
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = !ref_clk;
   end
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      {rst, iow_n, ior_n, dack_n} = 4'hf;
      {aen, base_load, dma_dual, adc_dma_en, adc_done} = 5'h00;
      {sa, sd_in, adc_raw, base_sel, irq_line_sel} = '0;
      {irq_enable, ev, dma_chan_sel} = '0;
      void'($urandom(28));
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      io(1'b0, 10'h23e, 16'h0000);
      chkb(sel, 1'b1);
      io(1'b0, 10'h240, 16'h0000);
      chkb(sel, 1'b0);
      ld(5'h1f);
      io(1'b0, 10'h3e6, 16'h0000);
      chkb(sel, 1'b1);
      ld(5'h11);
      aen <= 1'b1;
      io(1'b0, 10'h220, 16'h0000);
      chkb(sel, 1'b0);
      aen <= 1'b0;
      push(4);
      repeat (4) begin
         io(1'b0, 10'h220, 16'h0000);
         chk(rd, q.pop_front());
         chkb(cs, 1'b0);
         chkb(oe, 1'b0);
      end
      for (int c = 0; c < 4; c++) begin
         dma_chan_sel <= 2'(c);
         repeat (4) @(posedge ref_clk);
         chk({14'h0000, dma_chan}, 16'(c));
      end
      adc_dma_en <= 1'b1;
      push(1);
      chkb(drq_a, 1'b1);
      aen <= 1'b1;
      dack_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      {aen, dack_n} <= 2'b01;
      void'(q.pop_front());
      repeat (6) @(posedge ref_clk);
      chkb(drq_a, 1'b0);
      {dma_dual, ev[3]} <= 2'b11;
      repeat (6) @(posedge ref_clk);
      chkb(drq_b, 1'b1);
      {dma_dual, ev[3], adc_dma_en} <= 3'b000;
      repeat (6) @(posedge ref_clk);
      chkb(drq_b, 1'b0);
      for (int k = 0; k < 6; k++) begin
         irq_enable <= 6'h01 << k;
         irq_line_sel <= 3'($urandom);
         if (k == 0) push(1);
         else ev[k] <= 1'b1;
         @(posedge ref_clk);
         ev <= 6'h00;
         repeat (6) @(posedge ref_clk);
         chk(irq_oe_n ^ 8'hff, 8'h01 << irq_line_sel);
         chk(irq_wire, 8'h01 << irq_line_sel);
         irq_enable <= 6'h00;
         repeat (6) @(posedge ref_clk);
         chk(irq_oe_n, 8'hff);
         irq_enable <= 6'h01 << k;
         repeat (6) @(posedge ref_clk);
         chk(irq_wire, 8'h01 << irq_line_sel);
         if (k == 0) io(1'b0, 10'h220, 16'h0000);
         io(1'b1, 10'h222, 16'h0001 << k);
         chk(irq_oe_n, 8'hff);
      end
      irq_enable <= 6'h04;
      ev[0] <= 1'b1;
      @(posedge ref_clk);
      ev <= 6'h00;
      repeat (6) @(posedge ref_clk);
      chk(irq_wire, 8'h01 << irq_line_sel);
      io(1'b1, 10'h222, 16'h0004);
      irq_enable <= 6'h00;
      io(1'b1, 10'h226, 16'h01b5);
      chk({7'h00, active_cfg}, 16'h01b5);
      chk({12'h000, mux_pos}, 16'h0005);
      chkb(mux_neg_gnd, 1'b1);
      io(1'b1, 10'h226, 16'h00b5);
      chk({7'h00, mux_neg_gnd, mux_pos, mux_neg}, 16'h005d);
      io(1'b1, 10'h226, 16'h00f5);
      chk({7'h00, active_cfg}, 16'h00b5);
      push(1);
      io(1'b0, 10'h220, 16'h0000);
      chk(rd, q[$] ^ 16'h8000);
      push(512);
      chkb(fifo_overflow, 1'b0);
      push(1);
      chkb(fifo_overflow, 1'b1);
      io(1'b1, 10'h222, 16'h0040);
      chkb(fifo_overflow, 1'b0);
      give_verdict();
   end
endmodule : iahi_core_tb
`default_nettype wire

// file: sim/iahi_host_model.sv
// host side model of the shared request lines
`timescale 1ns/10ps
`default_nettype none
module iahi_host_model (
   input wire logic [7:0] irq_out,
   input wire logic [7:0] irq_oe_n,
   output logic [7:0] irq_wire
);
   // a released line falls to its pull-down level
   assign irq_wire = irq_out & ~irq_oe_n;
endmodule : iahi_host_model
`default_nettype wire
